// file: rctm_top.sv
// Fast internal RC trim, dither, clock switching and fail monitor
// Functional notes
// - Fast RC is powered unless primary source runs in external or crystal mode; always powered after failure.
// - Range bit picks nominal 9.7 MHz low or 14.55 MHz high range.
// - Software trims the RC by about three percent either way.
// - Without dither, applied 4-bit trim is trim a field 0, or a field of trim a or b when sequence enable is set.
// - Sequence and dither enables clear: only the static trim field sets frequency.
// - Sequencing: eight-way mux of trim fields indexed by wrap counter bits 5..3.
// - Dither mode: low four bits of a 15-bit shift register drive trim.
// - Dither acts only while its enable bit is set.
// - Shift register steps when wrap counter bit 3 toggles.
// - Configuration 1x disables switching and fail monitor; this is default.
// - Detected failure with monitor on raises trap and moves clock to fast RC.
// - Failure loads current source with RC code, sets fail flag, clears request.
// - Oscillator not started at power-up expiry: trap, RC, shut oscillator off.
// - Slow RC keeps running for the watchdog regardless of main clock failure.
// - Switching only between primary and RC groups; primary choice follows fuse.
// - Switching disabled: fuses pick oscillator; current source only reflects it.
// - After power-on reset the clock source follows the configuration fuses.
// - Initial source: 00 RC, 01 RC with PLL, 10 primary, 11 primary with PLL.
// - Configuration 01 enables switching only; 00 enables switching and monitor.
//
// The APB slave port and the register offsets were decided locally.
module rctm_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [1:0]  initial_source_sel,
  input  wire logic [1:0]  primary_mode_sel,
  input  wire logic [1:0]  switch_monitor_cfg,
  input  wire logic [2:0]  pwm_roll,
  input  wire logic        power_up_done,
  input  wire logic        primary_clk_ok,
  output logic [3:0]       trim_value,
  output logic             fast_rc_power,
  output logic             fast_rc_range,
  output logic             primary_osc_power,
  output logic             pll_en,
  output logic [2:0]       current_source_sel,
  output logic             clock_fail_trap,
  output logic             slow_rc_power
);
  import rctm_pkg::*;

  // Register state
  logic [3:0]  fld [SEQ_ENTRIES];
  logic        switch_request;
  logic        new_group;
  logic        range_sel;
  logic        clock_fail_flag;
  logic        sequence_en;
  logic        random_dither_en;
  logic        failed;
  logic        fuse_ld;
  logic        fuse_go;
  logic [1:0]  init_q;
  logic [1:0]  pmode_q;
  logic [1:0]  cfg_q;
  logic        ok_s1;
  logic        ok_s2;
  logic        roll3_prev;
  logic [LFSR_W-1:0] lfsr;

  // APB decode
  wire         setup_acc  = psel & penable;
  wire         next_pready = setup_acc & ~pready;
  wire         wr_fire    = setup_acc & pready & pwrite;
  wire         hit_ctrl   = paddr == OFF_CTRL;
  wire         hit_trima  = paddr == OFF_TRIMA;
  wire         hit_trimb  = paddr == OFF_TRIMB;
  wire         hit_stat   = paddr == OFF_STAT;
  wire         hit        = hit_ctrl | hit_trima | hit_trimb | hit_stat;
  wire         wr_ctrl    = wr_fire & hit_ctrl;
  wire         wr_trima   = wr_fire & hit_trima;
  wire         wr_trimb   = wr_fire & hit_trimb;

  // Fuse decode
  wire         sw_en      = ~cfg_q[1];
  wire         mon_en     = cfg_q == CFG_SW_MON;
  wire         on_primary = current_source_sel[1];
  wire [2:0]   pri_code   = {2'b01, init_q[0]};
  wire [2:0]   fuse_code  = {1'b0, init_q};

  // A primary clock that is not running once power-up delay has ended is a failure
  wire         fail_det   = fuse_ld & mon_en & on_primary & power_up_done & ~ok_s2;
  wire         sw_fire    = fuse_ld & sw_en & switch_request & ~fail_det;

  // Trim selection
  wire         roll_step  = random_dither_en & (pwm_roll[0] ^ roll3_prev);
  wire [3:0]   seq_pick   = fld[pwm_roll];
  wire [3:0]   next_trim;
  assign next_trim = random_dither_en ? lfsr[3:0] :
                     sequence_en ? seq_pick :
                     fld[0];

  // Next current source
  logic [2:0]  next_src;
  always_comb
  begin
    next_src = current_source_sel;
    if (!fuse_go || !sw_en)
      next_src = fuse_code;
    else if (fail_det)
      next_src = SRC_RC;
    else if (sw_fire)
      next_src = new_group ? pri_code : SRC_RC;
  end

  wire next_pri_on = next_src[1] & (pmode_q != PMODE_OFF) & ~failed & ~fail_det;
  wire next_rc_on  = ~(next_src[1] & (pmode_q == PMODE_EXT || pmode_q == PMODE_XTAL)) | failed;

  // Read mux
  wire [31:0] rd_ctrl  = {17'h0, current_source_sel, 6'h0, random_dither_en, sequence_en,
                          clock_fail_flag, range_sel, new_group, switch_request};
  wire [31:0] rd_trima = {16'h0, fld[3], fld[2], fld[1], fld[0]};
  wire [31:0] rd_trimb = {16'h0, fld[7], fld[6], fld[5], fld[4]};
  wire [31:0] rd_stat  = {21'h0, pwm_roll, sw_en, mon_en, primary_osc_power,
                          fast_rc_power, trim_value};
  wire [31:0] rd_mux   = hit_ctrl  ? rd_ctrl  :
                         hit_trima ? rd_trima :
                         hit_trimb ? rd_trimb :
                         hit_stat  ? rd_stat  : 32'h0;

  // Pin input crosses into pclk through two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ok_s1 <= 1'b0;
      ok_s2 <= 1'b0;
    end
    else
    begin
      ok_s1 <= primary_clk_ok;
      ok_s2 <= ok_s1;
    end
  end

  // Fuses are caught on the first edge after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fuse_ld <= 1'b0;
      init_q  <= 2'h0;
      pmode_q <= 2'h0;
      cfg_q   <= CFG_OFF;
    end
    else if (!fuse_ld)
    begin
      fuse_ld <= 1'b1;
      init_q  <= initial_source_sel;
      pmode_q <= primary_mode_sel;
      cfg_q   <= switch_monitor_cfg;
    end
  end

  // Source takes the caught fuses one edge later, even with switching enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fuse_go <= 1'b0;
    else
      fuse_go <= fuse_ld;
  end

  // APB handshake: one wait state, data and error registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= next_pready;
      prdata  <= next_pready ? rd_mux : 32'h0;
      pslverr <= next_pready & ~hit;
    end
  end

  // Trim fields, entry 0 is the static trim
  genvar gi;
  generate
    for (gi = 0; gi < SEQ_ENTRIES; gi++)
    begin : g_fld
      localparam int LANE = (gi % TRIM_PER_REG) * TRIM_W;
      wire wr_me = (gi < TRIM_PER_REG) ? wr_trima : wr_trimb;
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          fld[gi] <= TRIM_RST;
        else if (wr_me)
          fld[gi] <= pwdata[LANE +: TRIM_W];
      end
    end
  endgenerate

  // Control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      new_group        <= 1'b0;
      range_sel        <= 1'b0;
      sequence_en      <= 1'b0;
      random_dither_en <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      new_group        <= pwdata[CTRL_GROUP];
      range_sel        <= pwdata[CTRL_RANGE];
      sequence_en      <= pwdata[CTRL_SEQEN];
      random_dither_en <= pwdata[CTRL_DITHEN];
    end
  end

  // Request is cleared by hardware on completion or failure; failure clear wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      switch_request <= 1'b0;
    else if (fail_det || sw_fire)
      switch_request <= 1'b0;
    else if (wr_ctrl)
      switch_request <= pwdata[CTRL_SWREQ];
  end

  // Fail flag: write one to clear, a new failure in that cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_fail_flag <= 1'b0;
    else if (fail_det)
      clock_fail_flag <= 1'b1;
    else if (wr_ctrl && pwdata[CTRL_FAIL])
      clock_fail_flag <= 1'b0;
  end

  // Failed oscillator stays off until software switches back to primary
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      failed <= 1'b0;
    else if (fail_det)
      failed <= 1'b1;
    else if (sw_fire && new_group)
      failed <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      roll3_prev <= 1'b0;
    else
      roll3_prev <= pwm_roll[0];
  end

  rctm_lfsr #(
    .WIDTH(LFSR_W)
  ) u_rctm_lfsr (
    .pclk    (pclk),
    .presetn (presetn),
    .step    (roll_step),
    .state   (lfsr)
  );

  // Oscillator outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_value         <= TRIM_RST;
      fast_rc_power      <= 1'b1;
      fast_rc_range      <= 1'b0;
      primary_osc_power  <= 1'b0;
      pll_en             <= 1'b0;
      current_source_sel <= SRC_RC;
      clock_fail_trap    <= 1'b0;
      slow_rc_power      <= 1'b1;
    end
    else
    begin
      trim_value         <= next_trim;
      fast_rc_power      <= next_rc_on;
      fast_rc_range      <= range_sel;
      primary_osc_power  <= next_pri_on;
      pll_en             <= next_src[0];
      current_source_sel <= next_src;
      clock_fail_trap    <= fail_det;
      slow_rc_power      <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_static_trim: assert property (
    !random_dither_en && !sequence_en |=> trim_value == $past(fld[0]))
    else $error("static trim not applied");

  chk_seq_trim: assert property (
    !random_dither_en && sequence_en |=> trim_value == $past(seq_pick))
    else $error("sequence trim mismatch");

  chk_dither_trim: assert property (
    random_dither_en |=> trim_value == $past(lfsr[3:0]))
    else $error("dither trim mismatch");

  chk_lfsr_step: assert property (
    !roll_step |=> $stable(lfsr))
    else $error("shift register moved without roll toggle");

  chk_lfsr_move: assert property (
    roll_step |=> !$stable(lfsr))
    else $error("shift register did not step");

  chk_fail_effect: assert property (
    fail_det |=> clock_fail_trap && clock_fail_flag && !switch_request
                 && current_source_sel == SRC_RC)
    else $error("failure handling incomplete");

  chk_fuse_source: assert property (
    fuse_ld && !fuse_go |=> current_source_sel == fuse_code)
    else $error("power-on source does not follow fuses");

  chk_fail_osc_off: assert property (
    fail_det |=> !primary_osc_power ##1 fast_rc_power)
    else $error("failed oscillator not shut off");

  chk_cfg_disabled: assert property (
    fuse_ld && cfg_q[1] |-> !fail_det ##1 current_source_sel == fuse_code)
    else $error("switching not disabled");

  chk_rc_power: assert property (
    fuse_ld && !next_src[1] |=> fast_rc_power)
    else $error("fast rc unpowered on rc source");

  chk_slow_rc: assert property (
    fuse_ld |-> slow_rc_power)
    else $error("slow rc stopped");

  cov_trap:    cover property (fail_det ##1 clock_fail_trap);
  cov_to_pri:  cover property (sw_fire && new_group);
  cov_seq_end: cover property (sequence_en && pwm_roll == 3'h7);
  cov_dither:  cover property (roll_step ##8 roll_step);
endmodule // rctm_top

// file: rctm_pkg.sv
// Constants shared by the internal RC trim, dither and fail monitor block
package rctm_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_TRIMA = 8'h04;
  localparam logic [7:0] OFF_TRIMB = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;

  // Control register fields
  localparam int CTRL_SWREQ  = 0;
  localparam int CTRL_GROUP  = 1;
  localparam int CTRL_RANGE  = 2;
  localparam int CTRL_FAIL   = 3;
  localparam int CTRL_SEQEN  = 4;
  localparam int CTRL_DITHEN = 5;
  localparam int CTRL_CUR_LO = 12;

  // Status register fields
  localparam int STAT_TRIM_LO = 0;
  localparam int STAT_RC_ON   = 4;
  localparam int STAT_PRI_ON  = 5;
  localparam int STAT_MON_EN  = 6;
  localparam int STAT_SW_EN   = 7;
  localparam int STAT_ROLL_LO = 8;

  // Trim layout: four 4-bit fields per trim register
  localparam int TRIM_W      = 4;
  localparam int SEQ_ENTRIES = 8;
  localparam int TRIM_PER_REG = 4;
  localparam logic [3:0] TRIM_RST = 4'h0;

  // Trim span around nominal, in percent
  localparam int TRIM_SPAN_PCT = 3;

  // Nominal oscillator frequencies in kHz for each range
  localparam int RC_LOW_KHZ  = 9700;
  localparam int RC_HIGH_KHZ = 14550;

  // Current source codes
  localparam logic [2:0] SRC_RC      = 3'h0;
  localparam logic [2:0] SRC_RC_PLL  = 3'h1;
  localparam logic [2:0] SRC_PRI     = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;

  // Primary oscillator mode codes
  localparam logic [1:0] PMODE_EXT  = 2'h0;
  localparam logic [1:0] PMODE_XTAL = 2'h2;
  localparam logic [1:0] PMODE_OFF = 2'h3;

  // Switch and monitor configuration codes
  localparam logic [1:0] CFG_SW_MON = 2'h0;
  localparam logic [1:0] CFG_SW     = 2'h1;
  localparam logic [1:0] CFG_OFF    = 2'h2;

  // Shift register width and nonzero seed
  localparam int LFSR_W = 15;
  localparam logic [14:0] LFSR_SEED = 15'h0001;
endpackage : rctm_pkg

// file: rctm_lfsr.sv
// 15-bit maximal-length shift register stepped on request
module rctm_lfsr #(
  parameter int WIDTH = rctm_pkg::LFSR_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             step,
  output logic [WIDTH-1:0]      state
);
  import rctm_pkg::*;

  logic             fb;
  logic [WIDTH-1:0] next_state;

  // Taps at the top two bits give the longest sequence for 15 bits
  assign fb         = state[WIDTH-1] ^ state[WIDTH-2];
  assign next_state = step ? {state[WIDTH-2:0], fb} : state;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= WIDTH'(LFSR_SEED);
    else
      state <= next_state;
  end

endmodule // rctm_lfsr

// file: rctm_pwm_model.sv
// PWM time base model that supplies wrap counter bits 5..3
module rctm_pwm_model #(
  parameter int PERIOD = 3
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  output logic [2:0]      pwm_roll
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] tbase;
  logic [5:0] wrap;

  assign pwm_roll = wrap[5:3];

  // Paused by the bench so trim reads see a settled index
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tbase <= 8'h00;
      wrap  <= 6'h00;
    end
    else if (run)
    begin
      tbase <= (tbase == 8'(PERIOD - 1)) ? 8'h00 : tbase + 8'h01;
      if (tbase == 8'(PERIOD - 1))
        wrap <= wrap + 6'h01;
    end
  end
endmodule // rctm_pwm_model

// file: rctm_bench.sv
// Self-checking bench for the RC trim, dither and fail monitor block
module rctm_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rctm_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, tr;
  logic [1:0]  init_sel, pmode, cfg;
  logic        pud, clk_ok, run, range, fr_pwr, po_pwr, pll_en, trap, sr_pwr;
  logic [2:0]  pwm_roll, src;
  logic [3:0]  trim;
  logic [14:0] lf;
  logic [64:0] exp_q[$];
  logic [64:0] rec;
  int          miscompares, samples_checked, traps;

  rctm_top u_rctm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .initial_source_sel(init_sel), .primary_mode_sel(pmode),
    .switch_monitor_cfg(cfg), .pwm_roll(pwm_roll), .power_up_done(pud),
    .primary_clk_ok(clk_ok), .trim_value(trim), .fast_rc_power(fr_pwr),
    .fast_rc_range(range), .primary_osc_power(po_pwr), .pll_en(pll_en),
    .current_source_sel(src), .clock_fail_trap(trap), .slow_rc_power(sr_pwr));

  rctm_pwm_model u_rctm_pwm_model (.pclk(pclk), .presetn(presetn), .run(run), .pwm_roll(pwm_roll));

  always #2.5 pclk = ~pclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; the expected read word and error flag go on the queue
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e, input logic err);
    int n;
    n = 0;
    exp_q.push_back({err, m, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %0t no ready from slave", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never drives psel twice at one edge
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  // Runs the time base until the wrap index moves on by one
  task automatic go_next();
    logic [2:0] tgt;
    int n;
    tgt = pwm_roll + 3'h1;
    n = 0;
    run <= 1'b1;
    do @(posedge pclk); while (pwm_roll !== tgt && ++n < 200);
    if (pwm_roll !== tgt)
    begin
      miscompares++;
      $display("[ERR] %0t wrap index stuck", $time);
    end
    run <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wrap_up();
    if (exp_q.size() != 0)
      miscompares++;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    if (trap === 1'b1)
      traps++;
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      rec = exp_q.pop_front();
      chk(prdata & rec[63:32], rec[31:0]);
      chk(32'(pslverr), 32'(rec[64]));
    end
  end

  initial
  begin
    #200us;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    init_sel = 2'b10; pmode = PMODE_XTAL; cfg = CFG_SW_MON; pud = 1; clk_ok = 1; run = 0;
    seed = 32'h26af;
    seed = xs(seed);
    tr = seed;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(src), 32'(SRC_PRI));
    chk(32'(sr_pwr), 32'h1);
    chk(32'(po_pwr), 32'h1);
    apb(1'b0, OFF_STAT, 0, 32'hc0, 32'hc0, 1'b0);
    wr(OFF_TRIMA, {16'h0, tr[15:0]});
    wr(OFF_TRIMB, {16'h0, tr[31:16]});
    go_next();
    apb(1'b0, OFF_STAT, 0, 32'hf, 32'(tr[3:0]), 1'b0);
    wr(OFF_CTRL, 32'h14);
    @(posedge pclk);
    chk(32'(range), 32'h1);
    repeat (8)
    begin
      go_next();
      apb(1'b0, OFF_STAT, 0, 32'h70f, {21'h0, pwm_roll, 4'h0, tr[pwm_roll*4 +: 4]}, 1'b0);
    end
    wr(OFF_CTRL, 32'h30);
    lf = LFSR_SEED;
    apb(1'b0, OFF_STAT, 0, 32'hf, 32'(lf[3:0]), 1'b0);
    repeat (4)
    begin
      go_next();
      lf = {lf[13:0], lf[14] ^ lf[13]};
      apb(1'b0, OFF_STAT, 0, 32'hf, 32'(lf[3:0]), 1'b0);
    end
    chk(32'(trim), 32'(lf[3:0]));
    wr(OFF_CTRL, 32'h10);
    apb(1'b0, OFF_STAT, 0, 32'hf, 32'(tr[pwm_roll*4 +: 4]), 1'b0);
    wr(OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk(32'(src), 32'(SRC_RC));
    chk(32'(fr_pwr), 32'h1);
    apb(1'b0, OFF_CTRL, 0, 32'h7001, 32'h0, 1'b0);
    // Switch back to primary; fuse bit 0 clear picks it without the PLL
    wr(OFF_CTRL, 32'h3);
    repeat (3) @(posedge pclk);
    chk(32'(src), 32'(SRC_PRI));
    clk_ok <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(traps, 1);
    chk(32'(src), 32'(SRC_RC));
    chk(32'(po_pwr), 32'h0);
    chk(32'(fr_pwr), 32'h1);
    apb(1'b0, OFF_CTRL, 0, 32'h7009, 32'h8, 1'b0);
    wr(OFF_CTRL, 32'h8);
    apb(1'b0, OFF_CTRL, 0, 32'h7009, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 0, 32'hffffffff, 32'h0, 1'b1);
    // Second power-on with switching and monitor off
    presetn <= 1'b0;
    cfg <= 2'b10;
    init_sel <= 2'b01;
    pmode <= PMODE_OFF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(32'(src), 32'(SRC_RC_PLL));
    chk(32'(pll_en), 32'h1);
    chk(32'(fr_pwr), 32'h1);
    apb(1'b0, OFF_STAT, 0, 32'hc0, 32'h0, 1'b0);
    wr(OFF_CTRL, 32'h3);
    repeat (3) @(posedge pclk);
    chk(32'(src), 32'(SRC_RC_PLL));
    wrap_up();
  end
endmodule // rctm_bench
